// ==== common/clk_gate_pkg.sv ====
// Constants, register map and power-mode encoding of the peripheral clock gate block.
// Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
package clk_gate_pkg;

	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned UNIT_W = 32;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned IRQ_W = 2;

	localparam logic [11:0] OFS_RUN_CFG = 12'h060;
	localparam logic [11:0] OFS_RUN_GATE = 12'h104;
	localparam logic [11:0] OFS_SLEEP_GATE = 12'h114;
	localparam logic [11:0] OFS_DEEP_GATE = 12'h124;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h200;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h204;
	localparam logic [11:0] OFS_FAULT_INFO = 12'h208;
	localparam logic [11:0] OFS_MODE_STATUS = 12'h20C;

	localparam int unsigned COMPARATOR2_GATE_BIT = 26;
	localparam int unsigned COMPARATOR1_GATE_BIT = 25;
	localparam int unsigned COMPARATOR0_GATE_BIT = 24;
	localparam int unsigned TMR_UNIT3_GATE_BIT = 19;
	localparam int unsigned TMR_UNIT2_GATE_BIT = 18;
	localparam int unsigned TMR_UNIT1_GATE_BIT = 17;
	localparam int unsigned TMR_UNIT0_GATE_BIT = 16;
	localparam int unsigned TWO_WIRE_UNIT_GATE_BIT = 12;
	localparam int unsigned SYNC_SERIAL1_GATE_BIT = 5;
	localparam int unsigned SYNC_SERIAL0_GATE_BIT = 4;
	localparam int unsigned ASYNC_SERIAL2_GATE_BIT = 2;
	localparam int unsigned ASYNC_SERIAL1_GATE_BIT = 1;
	localparam int unsigned ASYNC_SERIAL0_GATE_BIT = 0;

	localparam int unsigned SLEEP_GATING_SELECT_BIT = 27;
	localparam int unsigned IRQ_FAULT_BIT = 0;
	localparam int unsigned IRQ_MODE_BIT = 1;

	localparam logic [31:0] GATE_RESET = 32'h00000000;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [31:0] ONE_WORD = 32'h00000001;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [4:0] IDX_RESET = 5'h00;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_DEEP = 3'b100
	} power_mode_t;

endpackage : clk_gate_pkg

// ==== src/periph_access_guard.sv ====
// Access guard that answers a bus fault for any access to an unclocked peripheral unit.
// Assumes one-cycle access strobes from the peripheral bus decoder, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module periph_access_guard (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [clk_gate_pkg::UNIT_W-1:0] clk_en_i,
	input wire logic [clk_gate_pkg::UNIT_W-1:0] periph_req_i,
	output logic fault_o,
	output logic [clk_gate_pkg::IDX_W-1:0] fault_unit_o
);

	logic [clk_gate_pkg::UNIT_W-1:0] blocked;
	logic [clk_gate_pkg::IDX_W-1:0] hit_idx;
	logic fault_d;

	assign blocked = periph_req_i & ~clk_en_i;
	assign fault_d = |blocked;

	// The lowest blocked unit is reported when several are hit at once.
	always_comb begin
		hit_idx = clk_gate_pkg::IDX_RESET;
		for (int i = clk_gate_pkg::UNIT_W - 1; i >= 0; i--) begin
			if (blocked[i]) begin
				hit_idx = i[clk_gate_pkg::IDX_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fault_o <= 1'b0;
			fault_unit_o <= clk_gate_pkg::IDX_RESET;
		end else begin
			fault_o <= fault_d;
			if (fault_d) begin
				fault_unit_o <= hit_idx;
			end
		end
	end

	chk_fault_on_gated: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(|(periph_req_i & ~clk_en_i)) |=> fault_o
	) else $error("access to unclocked unit gave no fault");

	chk_no_fault_clocked: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		((periph_req_i & ~clk_en_i) == '0) |=> !fault_o
	) else $error("fault raised for a clocked unit");

endmodule : periph_access_guard
`default_nettype wire

// ==== src/deep_sleep_periph_clock_gate.sv ====
// Peripheral clock gating with run, sleep and deep-sleep gate registers behind APB.
// Assumes mode requests and peripheral access strobes come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_periph_clock_gate (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [clk_gate_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [clk_gate_pkg::DATA_W-1:0] pwdata_i,
	output logic [clk_gate_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sleep_i,
	input wire logic deep_sleep_i,
	input wire logic [clk_gate_pkg::UNIT_W-1:0] periph_req_i,
	output logic [clk_gate_pkg::UNIT_W-1:0] unit_clk_en_o,
	output logic periph_fault_o,
	output logic [clk_gate_pkg::IDX_W-1:0] fault_unit_o,
	output logic irq_o
);

	// Writable gate bits; every other bit position is reserved.
	localparam logic [31:0] GATE_WR_MASK =
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::COMPARATOR2_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::COMPARATOR1_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::COMPARATOR0_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::TMR_UNIT3_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::TMR_UNIT2_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::TMR_UNIT1_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::TMR_UNIT0_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::TWO_WIRE_UNIT_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::SYNC_SERIAL1_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::SYNC_SERIAL0_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::ASYNC_SERIAL2_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::ASYNC_SERIAL1_GATE_BIT) |
		(clk_gate_pkg::ONE_WORD << clk_gate_pkg::ASYNC_SERIAL0_GATE_BIT);
	localparam logic [31:0] CFG_WR_MASK =
		clk_gate_pkg::ONE_WORD << clk_gate_pkg::SLEEP_GATING_SELECT_BIT;

	// Register state.
	logic [31:0] run_gate_reg_q;
	logic [31:0] sleep_gate_reg_q;
	logic [31:0] deep_sleep_gate_reg_q;
	logic [31:0] run_clock_config_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_status_d;
	logic [1:0] irq_mask_q;
	logic [31:0] clk_en_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	clk_gate_pkg::power_mode_t mode_q;
	clk_gate_pkg::power_mode_t mode_d;

	// Bus decode.
	logic setup_phase;
	logic access_wait;
	logic xfer_done;
	logic wr_fire;
	logic hit_run_cfg;
	logic hit_run_gate;
	logic hit_sleep_gate;
	logic hit_deep_gate;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_fault_info;
	logic hit_mode_status;
	logic addr_mapped;
	logic [31:0] rdata_d;
	logic [31:0] gate_wdata;

	// Gating selection.
	logic sleep_gating_select;
	logic use_sleep;
	logic use_deep;
	logic [31:0] eff_en;

	// Events and fault path.
	logic guard_fault;
	logic [clk_gate_pkg::IDX_W-1:0] guard_unit;
	logic mode_change_evt;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	// A transfer waits exactly one cycle in the access phase, so read data
	// and the error answer come from flip-flops.
	assign setup_phase = psel_i && !penable_i;
	assign access_wait = psel_i && penable_i && !pready_q;
	assign xfer_done = psel_i && penable_i && pready_q;
	assign wr_fire = xfer_done && pwrite_i && !pslverr_q;

	assign hit_run_cfg = (paddr_i == clk_gate_pkg::OFS_RUN_CFG);
	assign hit_run_gate = (paddr_i == clk_gate_pkg::OFS_RUN_GATE);
	assign hit_sleep_gate = (paddr_i == clk_gate_pkg::OFS_SLEEP_GATE);
	assign hit_deep_gate = (paddr_i == clk_gate_pkg::OFS_DEEP_GATE);
	assign hit_irq_status = (paddr_i == clk_gate_pkg::OFS_IRQ_STATUS);
	assign hit_irq_mask = (paddr_i == clk_gate_pkg::OFS_IRQ_MASK);
	assign hit_fault_info = (paddr_i == clk_gate_pkg::OFS_FAULT_INFO);
	assign hit_mode_status = (paddr_i == clk_gate_pkg::OFS_MODE_STATUS);
	assign addr_mapped = hit_run_cfg || hit_run_gate || hit_sleep_gate || hit_deep_gate ||
		hit_irq_status || hit_irq_mask || hit_fault_info || hit_mode_status;

	// Reserved bits are dropped on write, so they always read back as zero.
	assign gate_wdata = pwdata_i & GATE_WR_MASK;

	assign rdata_d = hit_run_cfg ? run_clock_config_q :
		hit_run_gate ? run_gate_reg_q :
		hit_sleep_gate ? sleep_gate_reg_q :
		hit_deep_gate ? deep_sleep_gate_reg_q :
		hit_irq_status ? {30'h00000000, irq_status_q} :
		hit_irq_mask ? {30'h00000000, irq_mask_q} :
		hit_fault_info ? {27'h0000000, fault_unit_o} :
		hit_mode_status ? {28'h0000000, sleep_gating_select, mode_q} :
		clk_gate_pkg::ZERO_WORD;

	// Power-mode tracker; deep-sleep takes priority over sleep.
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			clk_gate_pkg::MODE_RUN: begin
				if (deep_sleep_i) begin
					mode_d = clk_gate_pkg::MODE_DEEP;
				end else if (sleep_i) begin
					mode_d = clk_gate_pkg::MODE_SLEEP;
				end
			end
			clk_gate_pkg::MODE_SLEEP: begin
				if (deep_sleep_i) begin
					mode_d = clk_gate_pkg::MODE_DEEP;
				end else if (!sleep_i) begin
					mode_d = clk_gate_pkg::MODE_RUN;
				end
			end
			clk_gate_pkg::MODE_DEEP: begin
				if (!deep_sleep_i) begin
					mode_d = sleep_i ? clk_gate_pkg::MODE_SLEEP : clk_gate_pkg::MODE_RUN;
				end
			end
			default: begin
				mode_d = clk_gate_pkg::MODE_RUN;
			end
		endcase
	end

	// Sleep registers steer the enables only under the select bit.
	assign sleep_gating_select = run_clock_config_q[clk_gate_pkg::SLEEP_GATING_SELECT_BIT];
	assign use_deep = sleep_gating_select && (mode_q == clk_gate_pkg::MODE_DEEP);
	assign use_sleep = sleep_gating_select && (mode_q == clk_gate_pkg::MODE_SLEEP);
	assign eff_en = use_deep ? deep_sleep_gate_reg_q :
		use_sleep ? sleep_gate_reg_q :
		run_gate_reg_q;

	assign mode_change_evt = (eff_en != clk_en_q);
	assign irq_set = {mode_change_evt, guard_fault};
	assign irq_clr = (wr_fire && hit_irq_status) ? pwdata_i[1:0] : clk_gate_pkg::IRQ_RESET;
	// A new event in the clearing cycle survives the clear.
	assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= clk_gate_pkg::ZERO_WORD;
		end else begin
			pready_q <= access_wait;
			if (setup_phase) begin
				pslverr_q <= !addr_mapped;
				prdata_q <= pwrite_i ? clk_gate_pkg::ZERO_WORD : rdata_d;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run_gate_reg_q <= clk_gate_pkg::GATE_RESET;
			sleep_gate_reg_q <= clk_gate_pkg::GATE_RESET;
			deep_sleep_gate_reg_q <= clk_gate_pkg::GATE_RESET;
			run_clock_config_q <= clk_gate_pkg::CFG_RESET;
			irq_mask_q <= clk_gate_pkg::IRQ_RESET;
		end else if (wr_fire) begin
			if (hit_run_gate) begin
				run_gate_reg_q <= gate_wdata;
			end
			if (hit_sleep_gate) begin
				sleep_gate_reg_q <= gate_wdata;
			end
			if (hit_deep_gate) begin
				deep_sleep_gate_reg_q <= gate_wdata;
			end
			if (hit_run_cfg) begin
				run_clock_config_q <= pwdata_i & CFG_WR_MASK;
			end
			if (hit_irq_mask) begin
				irq_mask_q <= pwdata_i[1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode_q <= clk_gate_pkg::MODE_RUN;
			clk_en_q <= clk_gate_pkg::GATE_RESET;
			irq_status_q <= clk_gate_pkg::IRQ_RESET;
			irq_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			clk_en_q <= eff_en;
			irq_status_q <= irq_status_d;
			irq_q <= |(irq_status_d & irq_mask_q);
		end
	end

	periph_access_guard u_guard (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clk_en_i(clk_en_q),
		.periph_req_i(periph_req_i),
		.fault_o(guard_fault),
		.fault_unit_o(guard_unit)
	);

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign unit_clk_en_o = clk_en_q;
	assign periph_fault_o = guard_fault;
	assign fault_unit_o = guard_unit;
	assign irq_o = irq_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_reset_zero: assert property (
		$rose(rst_n_i) |-> (deep_sleep_gate_reg_q == clk_gate_pkg::GATE_RESET) &&
			(unit_clk_en_o == clk_gate_pkg::GATE_RESET)
	) else $error("gate state not zero after reset");

	chk_enable_follows: assert property (
		##1 (unit_clk_en_o == $past(eff_en))
	) else $error("unit clock enables do not follow selected register");

	chk_run_when_unselected: assert property (
		!sleep_gating_select |=> (unit_clk_en_o == $past(run_gate_reg_q))
	) else $error("run gating not applied without select bit");

	chk_deep_selected: assert property (
		(sleep_gating_select && mode_q == clk_gate_pkg::MODE_DEEP)
			|=> (unit_clk_en_o == $past(deep_sleep_gate_reg_q))
	) else $error("deep-sleep register not applied in deep-sleep");

	chk_reserved_zero: assert property (
		((run_gate_reg_q | sleep_gate_reg_q | deep_sleep_gate_reg_q) & ~GATE_WR_MASK) == '0
	) else $error("reserved gate bit is set");

	chk_deep_write: assert property (
		(wr_fire && paddr_i == clk_gate_pkg::OFS_DEEP_GATE)
			|=> (deep_sleep_gate_reg_q == ($past(pwdata_i) & GATE_WR_MASK))
	) else $error("write at deep-sleep offset not stored");

	chk_deep_write_idle: assert property (
		(wr_fire && hit_deep_gate && !use_deep) ##1 (!use_deep && $stable(use_sleep))
			|-> $stable(eff_en)
	) else $error("deep-sleep write changed clocks outside deep-sleep");

	chk_comparator_bits: assert property (
		(wr_fire && hit_deep_gate) |=> (deep_sleep_gate_reg_q[26:24] == $past(pwdata_i[26:24]))
	) else $error("comparator gate bits not writable");

	chk_serial_bits: assert property (
		(wr_fire && hit_deep_gate) |=> (deep_sleep_gate_reg_q[2:0] == $past(pwdata_i[2:0]))
	) else $error("async serial gate bits not writable");

	chk_apb_answer: assert property (
		(setup_phase ##1 (psel_i && penable_i)) |-> !pready_o ##1 pready_o
	) else $error("APB answer not one wait state");

	chk_irq_level: assert property (
		##1 (irq_o == |($past(irq_status_d) & $past(irq_mask_q)))
	) else $error("interrupt output does not match masked status");

	cov_deep_entry: cover property (
		sleep_gating_select && mode_q == clk_gate_pkg::MODE_DEEP && deep_sleep_gate_reg_q != '0
	);
	cov_fault: cover property (periph_fault_o && irq_o);
	cov_set_clear: cover property (irq_set[0] && irq_clr[0]);
	cov_err_answer: cover property (pready_o && pslverr_o);

endmodule : deep_sleep_periph_clock_gate
`default_nettype wire

// ==== dv/deep_sleep_periph_clock_gate_tb.sv ====
// Self-checking testbench of the peripheral clock gate: registers, mode selection, faults, irq.
// Assumes the design package is compiled first and an APB slave that may insert wait states.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_periph_clock_gate_tb;
	localparam logic [31:0] GATE_MASK = 32'h070F1037;
	localparam logic [31:0] SEL = 32'h08000000;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic sleep = 1'b0;
	logic deep = 1'b0;
	logic [31:0] req = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] en;
	logic fault;
	logic [4:0] funit;
	logic irq;
	logic [31:0] rd;
	logic err;
	logic [31:0] rg_run;
	logic [31:0] rg_slp;
	logic [31:0] rg_deep;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;

	deep_sleep_periph_clock_gate DUT (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep), .deep_sleep_i(deep),
		.periph_req_i(req), .unit_clk_en_o(en), .periph_fault_o(fault),
		.fault_unit_o(funit), .irq_o(irq)
	);

	always #20 clk_i = ~clk_i;

	task end_sim;
		$display("Checks %0d, errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Holds the request until pready is sampled high, then takes data and releases.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] exp_en(input int m, input int s, input logic [31:0] r,
		input logic [31:0] sl, input logic [31:0] dp);
		if (s == 0 || m == 0) begin
			return r;
		end
		return (m == 1) ? sl : dp;
	endfunction : exp_en

	task set_mode(input logic s, input logic d);
		@(posedge clk_i);
		sleep <= s;
		deep <= d;
		repeat (4) @(posedge clk_i);
	endtask : set_mode

	// Pulses one unit request and checks fault, index, status and the interrupt line.
	task fault_try(input int u, input logic exp_f, input logic im);
		@(posedge clk_i);
		req <= 32'h00000001 << u;
		@(posedge clk_i);
		req <= 32'h00000000;
		@(posedge clk_i);
		chk("periph_fault", {31'h00000000, fault}, {31'h00000000, exp_f});
		if (exp_f) chk("fault_unit", {27'h0000000, funit}, 32'(u));
		@(posedge clk_i);
		chk("irq", {31'h00000000, irq}, {31'h00000000, exp_f & im});
		apb(1'b0, clk_gate_pkg::OFS_IRQ_STATUS, 32'h00000000);
		chk("irq_status", rd & 32'h00000001, {31'h00000000, exp_f});
		apb(1'b1, clk_gate_pkg::OFS_IRQ_STATUS, 32'h00000001);
		repeat (2) @(posedge clk_i);
		chk("irq_cleared", {31'h00000000, irq}, 32'h00000000);
	endtask : fault_try

	initial begin
		rd = $urandom(94);
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, clk_gate_pkg::OFS_DEEP_GATE, 32'h00000000);
		chk("deep_gate_reset", rd, 32'h00000000);
		apb(1'b0, clk_gate_pkg::OFS_RUN_GATE, 32'h00000000);
		chk("run_gate_reset", rd, 32'h00000000);
		apb(1'b0, clk_gate_pkg::OFS_SLEEP_GATE, 32'h00000000);
		chk("sleep_gate_reset", rd, 32'h00000000);
		chk("unit_clk_en_reset", en, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			rg_deep = (i == 0) ? 32'hFFFFFFFF : $urandom;
			apb(1'b1, clk_gate_pkg::OFS_DEEP_GATE, rg_deep);
			apb(1'b0, clk_gate_pkg::OFS_DEEP_GATE, 32'h00000000);
			chk("deep_gate_rw", rd, rg_deep & GATE_MASK);
			chk("deep_gate_err", {31'h00000000, err}, 32'h00000000);
		end
		apb(1'b1, 12'h128, 32'hFFFFFFFF);
		chk("unmapped_wr_err", {31'h00000000, err}, 32'h00000001);
		apb(1'b0, 12'h128, 32'h00000000);
		chk("unmapped_rd", rd, 32'h00000000);
		rg_run = $urandom & GATE_MASK;
		rg_slp = $urandom & GATE_MASK;
		rg_deep = $urandom & GATE_MASK;
		apb(1'b1, clk_gate_pkg::OFS_RUN_GATE, rg_run);
		apb(1'b1, clk_gate_pkg::OFS_SLEEP_GATE, rg_slp);
		apb(1'b1, clk_gate_pkg::OFS_DEEP_GATE, rg_deep);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, clk_gate_pkg::OFS_RUN_CFG, (s == 1) ? SEL : 32'h00000000);
			for (int m = 0; m < 3; m++) begin
				set_mode(m == 1, m == 2);
				chk("unit_clk_en", en, exp_en(m, s, rg_run, rg_slp, rg_deep));
			end
		end
		set_mode(1'b0, 1'b0);
		rg_deep = ~rg_deep & GATE_MASK;
		apb(1'b1, clk_gate_pkg::OFS_DEEP_GATE, rg_deep);
		repeat (4) @(posedge clk_i);
		chk("en_run_after_deep_wr", en, rg_run);
		apb(1'b1, clk_gate_pkg::OFS_IRQ_STATUS, 32'h00000003);
		set_mode(1'b0, 1'b1);
		chk("en_deep_applied", en, rg_deep);
		apb(1'b0, clk_gate_pkg::OFS_IRQ_STATUS, 32'h00000000);
		chk("irq_mode_evt", rd, {30'h00000000, rg_run != rg_deep, 1'b0});
		apb(1'b0, clk_gate_pkg::OFS_MODE_STATUS, 32'h00000000);
		chk("mode_status", rd, 32'h0000000C);
		apb(1'b1, clk_gate_pkg::OFS_MODE_STATUS, 32'hFFFFFFFF);
		chk("ro_write_err", {31'h00000000, err}, 32'h00000000);
		apb(1'b1, clk_gate_pkg::OFS_IRQ_MASK, 32'h00000001);
		apb(1'b1, clk_gate_pkg::OFS_IRQ_STATUS, 32'h00000003);
		for (int i = 0; i < 10; i++) begin
			int u;
			u = (i == 0) ? 3 : int'($urandom_range(31, 0));
			fault_try(u, ~rg_deep[u], 1'b1);
			if (~rg_deep[u]) begin
				apb(1'b0, clk_gate_pkg::OFS_FAULT_INFO, 32'h00000000);
				chk("fault_info", rd, 32'(u));
			end
		end
		apb(1'b1, clk_gate_pkg::OFS_IRQ_MASK, 32'h00000000);
		fault_try(3, 1'b1, 1'b0);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, clk_gate_pkg::OFS_DEEP_GATE, 32'h00000000);
		chk("deep_gate_rerun", rd, 32'h00000000);
		chk("en_rerun", en, 32'h00000000);
		end_sim();
	end
endmodule : deep_sleep_periph_clock_gate_tb
`default_nettype wire
